// File: hw/ivpm_pkg.sv
package ivpm_pkg;
   localparam logic [15:0] VEC_BASE      = 16'hFFC0;
   localparam logic [15:0] VEC_RESET     = 16'hFFFE;
   localparam logic [15:0] VEC_NMI       = 16'hFFFC;
   localparam logic [15:0] VEC_T2_CH0    = 16'hFFFA;
   localparam logic [15:0] VEC_T2_SHARED = 16'hFFF8;
   localparam logic [15:0] VEC_WDT_IV    = 16'hFFF4;
   localparam logic [15:0] VEC_T1_CH0    = 16'hFFF2;
   localparam logic [15:0] VEC_T1_SHARED = 16'hFFF0;
   localparam logic [15:0] VEC_SER_RX    = 16'hFFEE;
   localparam logic [15:0] VEC_SER_TX    = 16'hFFEC;
   localparam logic [15:0] VEC_CONV      = 16'hFFEA;
   localparam logic [15:0] VEC_PORT2     = 16'hFFE6;
   localparam logic [15:0] VEC_PORT1     = 16'hFFE4;
   localparam logic [15:0] VEC_BLANK     = 16'hFFFF;
   // priorities, one bit per slot of the pending vector
   localparam int PRI_RESET = 31;
   localparam int PRI_NMI   = 30;
   localparam int PRI_T2C0  = 29;
   localparam int PRI_T2SH  = 28;
   localparam int PRI_WDT   = 26;
   localparam int PRI_T1C0  = 25;
   localparam int PRI_T1SH  = 24;
   localparam int PRI_SRX   = 23;
   localparam int PRI_STX   = 22;
   localparam int PRI_CONV  = 21;
   localparam int PRI_P2    = 19;
   localparam int PRI_P1    = 18;
   // mode encoding as written to the core's mode field
   localparam logic [2:0] MODE_RUN = 3'h0;
   localparam logic [2:0] MODE_S0  = 3'h1;
   localparam logic [2:0] MODE_S1  = 3'h2;
   localparam logic [2:0] MODE_S2  = 3'h3;
   localparam logic [2:0] MODE_S3  = 3'h4;
   localparam logic [2:0] MODE_S4  = 3'h5;
   typedef enum logic [2:0] {
      IVPM_IDLE  = 3'b001,
      IVPM_FETCH = 3'b010,
      IVPM_SERVE = 3'b100
   } ivpm_state_e;
endpackage

// File: hw/ivpm_ctrl.sv
`timescale 1ns/1ps
module ivpm_ctrl
   import ivpm_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // reset sources
   input  wire logic        powerup_reset_flag,
   input  wire logic        pin_reset_flag,
   input  wire logic        watchdog_event_flag,
   input  wire logic        flash_key_violation_flag,
   input  wire logic        fetch_out_of_range,
   // non-maskable sources and their individual enables
   input  wire logic        nonmask_pin_flag,
   input  wire logic        osc_fault_flag,
   input  wire logic        flash_access_violation_flag,
   input  wire logic [2:0]  nmi_enable,
   // maskable sources
   input  wire logic        gie,
   input  wire logic        second_timer_channel0,
   input  wire logic        second_timer_channel1,
   input  wire logic        second_timer_channel2,
   input  wire logic        second_timer_overflow_flag,
   input  wire logic        watchdog_interval_flag,
   input  wire logic        first_timer_channel0,
   input  wire logic        first_timer_shared_flags,
   input  wire logic        serial_a_rx_flag,
   input  wire logic        serial_b_rx_flag,
   input  wire logic        serial_a_tx_flag,
   input  wire logic        serial_b_tx_flag,
   input  wire logic        converter_done_flag,
   input  wire logic [7:0]  port2_change_flags,
   input  wire logic [7:0]  port1_change_flags,
   input  wire logic [15:0] maskable_enable,
   // core handshake
   input  wire logic [2:0]  mode_request,
   input  wire logic        mode_write,
   input  wire logic        irq_return,
   input  wire logic        irq_ack,
   input  wire logic        osc_used_in_run,
   // vector fetch port to memory
   output logic [15:0]      vec_addr,
   output logic             vec_read,
   input  wire logic [15:0] vec_data,
   // answers to the core
   output logic             irq_req,
   output logic [15:0]      handler_pc,
   output logic             handler_valid,
   output logic             sys_reset_req,
   output logic [2:0]       run_mode_state,
   output logic             core_halt,
   output logic             main_clk_en,
   output logic             subsystem_clock_en,
   output logic             aux_clk_en,
   output logic             osc_gen_en,
   output logic             crystal_en
);
   import ivpm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pending vector: bit index equals priority
   logic [31:0] pend;
   logic [4:0]  win_pri;
   logic        win_any;
   logic [15:0] win_vec;

   // sources outside the clock domain are assumed synchronised by their owners
   always_comb begin
      pend = '0;
      pend[PRI_RESET] = powerup_reset_flag | pin_reset_flag | watchdog_event_flag
                      | flash_key_violation_flag | fetch_out_of_range;
      pend[PRI_NMI]   = |({nonmask_pin_flag, osc_fault_flag, flash_access_violation_flag}
                        & nmi_enable);
      pend[PRI_T2C0]  = gie & maskable_enable[0] & second_timer_channel0;
      pend[PRI_T2SH]  = gie & maskable_enable[1] & (second_timer_channel1 | second_timer_channel2
                        | second_timer_overflow_flag);
      pend[PRI_WDT]   = gie & maskable_enable[2] & watchdog_interval_flag;
      pend[PRI_T1C0]  = gie & maskable_enable[3] & first_timer_channel0;
      pend[PRI_T1SH]  = gie & maskable_enable[4] & first_timer_shared_flags;
      pend[PRI_SRX]   = gie & maskable_enable[5] & (serial_a_rx_flag | serial_b_rx_flag);
      pend[PRI_STX]   = gie & maskable_enable[6] & (serial_a_tx_flag | serial_b_tx_flag);
      pend[PRI_CONV]  = gie & maskable_enable[7] & converter_done_flag;
      pend[PRI_P2]    = gie & maskable_enable[8] & (|port2_change_flags);
      pend[PRI_P1]    = gie & maskable_enable[9] & (|port1_change_flags);
   end

   // highest set bit wins; ascending scan lets the later, higher one overwrite
   always_comb begin
      win_pri = 5'h0;
      win_any = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (pend[i]) begin
            win_pri = 5'(i);
            win_any = 1'b1;
         end
      end
      // vector word address grows two bytes per priority step from the base
      win_vec = VEC_BASE + {10'h000, win_pri, 1'b0};
   end

   ////////////////////////////////////////////////////////////////////////////
   // fetch sequencer
   ivpm_state_e state_r;
   ivpm_state_e state_nxt;
   logic        boot_check_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         IVPM_IDLE: begin
            if (win_any || boot_check_r) begin
               state_nxt = IVPM_FETCH;
            end
         end
         IVPM_FETCH: begin
            state_nxt = IVPM_SERVE;
         end
         IVPM_SERVE: begin
            if (irq_ack || sys_reset_req) begin
               state_nxt = IVPM_IDLE;
            end
         end
         default: begin
            state_nxt = IVPM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= IVPM_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // the reset vector is read once after reset to check for blank memory
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         boot_check_r <= 1'b1;
      end else if (state_r == IVPM_FETCH) begin
         boot_check_r <= 1'b0;
      end
   end

   // the fetch address is held in a flop; memory answers in the same cycle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         vec_addr <= VEC_RESET;
         vec_read <= 1'b0;
      end else if (state_r == IVPM_IDLE && (win_any || boot_check_r)) begin
         vec_addr <= boot_check_r ? VEC_RESET : win_vec;
         vec_read <= 1'b1;
      end else begin
         vec_read <= 1'b0;
      end
   end

   logic blank_boot;
   assign blank_boot = boot_check_r && state_r == IVPM_FETCH && vec_data == VEC_BLANK;

   // the fetched word is the new program counter
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         handler_pc    <= 16'h0000;
         handler_valid <= 1'b0;
         sys_reset_req <= 1'b0;
      end else if (state_r == IVPM_FETCH) begin
         handler_pc    <= vec_data;
         handler_valid <= !blank_boot;
         sys_reset_req <= vec_addr == VEC_RESET && !boot_check_r;
      end else if (state_r == IVPM_SERVE && irq_ack) begin
         handler_valid <= 1'b0;
         sys_reset_req <= 1'b0;
      end else begin
         sys_reset_req <= 1'b0;
      end
   end

   assign irq_req = state_r == IVPM_SERVE && handler_valid;

   ////////////////////////////////////////////////////////////////////////////
   // operating mode; the mode left for a handler is saved for its return
   logic [2:0] saved_mode_r;
   logic       in_handler_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         run_mode_state <= MODE_RUN;
         saved_mode_r   <= MODE_RUN;
         in_handler_r   <= 1'b0;
      end else if (blank_boot) begin
         run_mode_state <= MODE_S4;
      end else if (state_r == IVPM_SERVE && irq_ack) begin
         saved_mode_r   <= run_mode_state;
         run_mode_state <= MODE_RUN;
         in_handler_r   <= 1'b1;
      end else if (irq_return && in_handler_r) begin
         run_mode_state <= saved_mode_r;
         in_handler_r   <= 1'b0;
      end else if (mode_write && mode_request <= MODE_S4) begin
         run_mode_state <= mode_request;
      end
   end

   // clock gating per mode; registered so gates never glitch
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         core_halt          <= 1'b0;
         main_clk_en        <= 1'b1;
         subsystem_clock_en <= 1'b1;
         aux_clk_en         <= 1'b1;
         osc_gen_en         <= 1'b1;
         crystal_en         <= 1'b1;
      end else begin
         core_halt          <= run_mode_state != MODE_RUN;
         main_clk_en        <= run_mode_state == MODE_RUN;
         subsystem_clock_en <= run_mode_state <= MODE_S1;
         aux_clk_en         <= run_mode_state != MODE_S4;
         osc_gen_en         <= run_mode_state == MODE_RUN || run_mode_state == MODE_S0
                               || run_mode_state == MODE_S2
                               || (run_mode_state == MODE_S1 && osc_used_in_run);
         crystal_en         <= run_mode_state != MODE_S4;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_fetch_then_serve;
      state_r == IVPM_FETCH ##1 state_r == IVPM_SERVE;
   endsequence

   a_reset_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == IVPM_IDLE && pend[PRI_RESET] && !boot_check_r) |=> vec_addr == VEC_RESET)
      else $error("reset source did not win arbitration");
   a_nmi_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == IVPM_IDLE && !boot_check_r && pend[31:30] == 2'b01) |=> vec_addr == VEC_NMI)
      else $error("nmi vector wrong");
   a_fetch_pc: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_fetch_then_serve |-> handler_pc == $past(vec_data))
      else $error("handler pc not the fetched word");
   a_vec_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
      vec_read |-> vec_addr >= VEC_BASE)
      else $error("vector address below table");
   a_blank_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst)
      blank_boot |=> run_mode_state == MODE_S4 ##1 !crystal_en && !aux_clk_en)
      else $error("blank memory did not enter deepest sleep");
   a_wake_restore: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == IVPM_SERVE && irq_ack && !blank_boot) |=> run_mode_state == MODE_RUN
      && saved_mode_r == $past(run_mode_state))
      else $error("wake did not save the mode");
   a_run_clocks: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run_mode_state == MODE_RUN |=> main_clk_en && subsystem_clock_en && aux_clk_en)
      else $error("clock off in run mode");
   a_level_two: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run_mode_state == MODE_S2 |=> !subsystem_clock_en && aux_clk_en && osc_gen_en && core_halt)
      else $error("level two gating wrong");
   a_level_three: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run_mode_state == MODE_S3 |=> !main_clk_en && aux_clk_en && !osc_gen_en)
      else $error("level three gating wrong");
   a_level_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run_mode_state == MODE_S0 |=> core_halt && !main_clk_en && subsystem_clock_en && aux_clk_en)
      else $error("level zero gating wrong");
   a_level_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (run_mode_state == MODE_S1 && !osc_used_in_run) |=> !osc_gen_en && subsystem_clock_en && core_halt)
      else $error("level one gating wrong");
   a_level_four: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run_mode_state == MODE_S4 |=> !main_clk_en && !subsystem_clock_en && !aux_clk_en && !osc_gen_en
      && !crystal_en && core_halt)
      else $error("level four gating wrong");
   a_reset_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sys_reset_req |=> !sys_reset_req)
      else $error("reset request longer than one cycle");
endmodule

// File: testbench/ivpm_vec_mem.sv
`timescale 1ns/1ps
module ivpm_vec_mem (
   input  wire logic        clk_sys,
   input  wire logic        blank,
   input  wire logic [15:0] vec_addr,
   input  wire logic        vec_read,
   output logic      [15:0] vec_data
);
   logic [15:0] junk_r = 16'h0000;
   logic        rd_d_r = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // moving pattern outside the read window, so a late sample never matches
   always_ff @(posedge clk_sys) begin
      junk_r <= junk_r + 16'h1357;
      rd_d_r <= vec_read;
   end
   // table word: high byte is the low address byte, low byte its inverse
   always_comb begin
      if (!(vec_read || rd_d_r) || vec_addr < 16'hFFC0) begin
         vec_data = ~junk_r;
      end else if (blank && vec_addr == 16'hFFFE) begin
         vec_data = 16'hFFFF;
      end else begin
         vec_data = {vec_addr[7:0], ~vec_addr[7:0]};
      end
   end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
   import ivpm_pkg::*;
   logic        clk_sys, sys_rst, gie, mode_write, irq_return, irq_ack, osc_used_in_run, blank;
   logic [21:0] src;
   logic [2:0]  nen, mode_request, run_mode_state;
   logic [15:0] men, vec_addr, vec_data, handler_pc;
   logic        vec_read, irq_req, handler_valid, sys_reset_req, core_halt;
   logic        main_clk_en, subsystem_clock_en, aux_clk_en, osc_gen_en, crystal_en;
   int          num_errors, samples_checked, rst_pulses;
   ////////////////////////////////////////////////////////////////////////
   // src bits: 0-13 maskable, 14-16 non-maskable, 17-21 reset sources
   ivpm_ctrl ivpm_ctrl_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .powerup_reset_flag(src[17]), .pin_reset_flag(src[18]),
      .watchdog_event_flag(src[19]), .flash_key_violation_flag(src[20]), .fetch_out_of_range(src[21]),
      .nonmask_pin_flag(src[14]), .osc_fault_flag(src[15]), .flash_access_violation_flag(src[16]),
      .nmi_enable(nen), .gie(gie), .second_timer_channel0(src[0]), .second_timer_channel1(src[1]),
      .second_timer_channel2(src[2]), .second_timer_overflow_flag(src[3]), .watchdog_interval_flag(src[4]),
      .first_timer_channel0(src[5]), .first_timer_shared_flags(src[6]), .serial_a_rx_flag(src[7]),
      .serial_b_rx_flag(src[8]), .serial_a_tx_flag(src[9]), .serial_b_tx_flag(src[10]),
      .converter_done_flag(src[11]), .port2_change_flags({4'h0, src[12], 3'h0}),
      .port1_change_flags({src[13], 7'h00}), .maskable_enable(men), .mode_request(mode_request),
      .mode_write(mode_write), .irq_return(irq_return), .irq_ack(irq_ack), .osc_used_in_run(osc_used_in_run),
      .vec_addr(vec_addr), .vec_read(vec_read), .vec_data(vec_data), .irq_req(irq_req),
      .handler_pc(handler_pc), .handler_valid(handler_valid), .sys_reset_req(sys_reset_req),
      .run_mode_state(run_mode_state), .core_halt(core_halt), .main_clk_en(main_clk_en),
      .subsystem_clock_en(subsystem_clock_en), .aux_clk_en(aux_clk_en), .osc_gen_en(osc_gen_en),
      .crystal_en(crystal_en));
   ivpm_vec_mem ivpm_vec_mem_inst (.clk_sys(clk_sys), .blank(blank), .vec_addr(vec_addr),
      .vec_read(vec_read), .vec_data(vec_data));
   ////////////////////////////////////////////////////////////////////////
   // clock and reset-request pulse counter
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (sys_reset_req === 1'b1) rst_pulses++;
   end
   function automatic logic [15:0] exp_vec(input int i);
      case (i)
         0: return 16'hFFFA;
         1, 2, 3: return 16'hFFF8;
         4: return 16'hFFF4;
         5: return 16'hFFF2;
         6: return 16'hFFF0;
         7, 8: return 16'hFFEE;
         9, 10: return 16'hFFEC;
         11: return 16'hFFEA;
         12: return 16'hFFE6;
         13: return 16'hFFE4;
         14, 15, 16: return 16'hFFFC;
         default: return 16'hFFFE;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // wait for a request under a bound, judge it, then acknowledge and drop flags
   task automatic serve(input logic [15:0] ev);
      int reads;
      reads = 0;
      // always let an edge pass first, so a request left over from the last call is never taken
      for (int k = 0; k < 20; k++) begin
         @(posedge clk_sys);
         #1;
         if (vec_read === 1'b1) reads++;
         if (irq_req === 1'b1) break;
      end
      `CHK("irq_req", 1'b1, irq_req)
      `CHK("vec_reads", 1, reads)
      `CHK("vec_addr", ev, vec_addr)
      `CHK("handler_pc", {ev[7:0], ~ev[7:0]}, handler_pc)
      `CHK("handler_valid", 1'b1, handler_valid)
      @(posedge clk_sys);
      irq_ack <= 1'b1;
      src <= '0;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
   endtask
   task automatic set_mode(input logic [2:0] m);
      @(posedge clk_sys);
      mode_request <= m;
      mode_write <= 1'b1;
      @(posedge clk_sys);
      mode_write <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_sources();
      int p;
      for (int i = 0; i < 22; i++) begin
         p = rst_pulses;
         @(posedge clk_sys);
         src[i] <= 1'b1;
         serve(exp_vec(i));
         repeat (2) @(posedge clk_sys);
         if (i > 16) `CHK("reset_pulses", 1, rst_pulses - p)
      end
      $display("test sources done");
   endtask
   // pairs pending together: the higher priority number must win
   task automatic t_priority();
      @(posedge clk_sys);
      src <= 22'h2001;
      serve(16'hFFFA);
      src <= 22'h2_4000;
      serve(16'hFFFE);
      src <= 22'h0280;
      serve(16'hFFEE);
      $display("test priority done");
   endtask
   // general enable off masks timers; nmi pin waits for its own enable only
   task automatic t_mask();
      int hits;
      hits = 0;
      @(posedge clk_sys);
      gie <= 1'b0;
      nen <= 3'b011;
      src <= 22'h4001;
      for (int k = 0; k < 10; k++) begin
         @(posedge clk_sys);
         #1;
         if (irq_req !== 1'b0) hits++;
      end
      `CHK("masked_irq", 0, hits)
      @(posedge clk_sys);
      nen <= 3'b100;
      serve(16'hFFFC);
      gie <= 1'b1;
      nen <= 3'b111;
      $display("test mask done");
   endtask
   // clock enables as {halt, main, sub, aux, gen, xtal}
   task automatic t_modes();
      logic [5:0] tbl [6] = '{6'h1F, 6'h2F, 6'h2D, 6'h27, 6'h25, 6'h20};
      logic [5:0] seen;
      for (int m = 5; m >= 0; m--) begin
         set_mode(m[2:0]);
         `CHK("mode", m[2:0], run_mode_state)
         seen = {core_halt, main_clk_en, subsystem_clock_en, aux_clk_en, osc_gen_en, crystal_en};
         `CHK("clocks", tbl[m], seen)
      end
      @(posedge clk_sys);
      osc_used_in_run <= 1'b1;
      set_mode(MODE_S1);
      `CHK("gen_kept", 1'b1, osc_gen_en)
      @(posedge clk_sys);
      osc_used_in_run <= 1'b0;
      set_mode(MODE_RUN);
      $display("test modes done");
   endtask
   task automatic t_wake();
      set_mode(MODE_S2);
      @(posedge clk_sys);
      src[0] <= 1'b1;
      serve(16'hFFFA);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("woken", MODE_RUN, run_mode_state)
      @(posedge clk_sys);
      irq_return <= 1'b1;
      @(posedge clk_sys);
      irq_return <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("restored", MODE_S2, run_mode_state)
      set_mode(MODE_RUN);
      $display("test wake done");
   endtask
   // blank reset word: deepest sleep, no request to the core
   task automatic t_blank();
      @(posedge clk_sys);
      blank <= 1'b1;
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      `CHK("blank_mode", MODE_S4, run_mode_state)
      `CHK("blank_xtal", 1'b0, crystal_en)
      `CHK("blank_irq", 1'b0, irq_req)
      $display("test blank done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog sized far above the few hundred cycles the tests need
   initial begin
      #200_000;
      num_errors++;
      complete_run();
   end
   initial begin
      // reset held, general enable on, memory programmed
      {sys_rst, gie, mode_write, irq_return, irq_ack, osc_used_in_run, blank} = 7'h60;
      {src, nen, mode_request, men} = {22'h0, 3'h7, 3'h0, 16'h03FF};
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      serve(16'hFFFE);
      t_sources();
      t_priority();
      t_mask();
      t_modes();
      t_wake();
      t_blank();
      complete_run();
   end
endmodule
